//--- core/i2cm_pkg.sv
// package: register map, fields, reset values and states of the bus master
package i2cm_pkg;
  localparam int          ADDR_W         = 16;
  localparam int          IDX_W          = 14;
  // register indices, byte address is four times the index
  localparam logic [13:0] IDX_RCV        = 14'h0200;
  localparam logic [13:0] IDX_TRN        = 14'h0202;
  localparam logic [13:0] IDX_RELOAD     = 14'h0204;
  localparam logic [13:0] IDX_CTRL       = 14'h0206;
  localparam logic [13:0] IDX_STAT       = 14'h0208;
  localparam logic [13:0] IDX_IRQ_STAT   = 14'h020C;
  localparam logic [13:0] IDX_IRQ_CLR    = 14'h020E;
  localparam logic [13:0] IDX_IRQ_EN     = 14'h0210;
  // reset values
  localparam logic [15:0] RST_RCV        = 16'h0000;
  localparam logic [15:0] RST_TRN        = 16'h00FF;
  localparam logic [15:0] RST_RELOAD     = 16'h0000;
  localparam logic [15:0] RST_CTRL       = 16'h0000;
  localparam logic [3:0]  RST_IRQ        = 4'h0;
  // control_word fields
  localparam int          CTL_EN         = 15;
  localparam int          CTL_HALT_IDLE  = 13;
  localparam int          CTL_ACK_VAL    = 5;
  localparam int          CTL_ACK_REQ    = 4;
  localparam int          CTL_RX_REQ     = 3;
  localparam int          CTL_STOP_REQ   = 2;
  localparam int          CTL_RS_REQ     = 1;
  localparam int          CTL_START_REQ  = 0;
  localparam logic [15:0] CTL_REQ_MASK   = 16'h001F;
  // status_word fields
  localparam int          ST_ACK         = 15;
  localparam int          ST_TX_ACTIVE   = 14;
  localparam int          ST_COLL        = 10;
  localparam int          ST_STOP        = 4;
  localparam int          ST_START       = 3;
  localparam int          ST_RX_FULL     = 1;
  localparam int          ST_TX_FULL     = 0;
  // interrupt status fields
  localparam int          IRQ_W          = 4;
  localparam int          IRQ_MASTER     = 0;
  localparam int          IRQ_COLL       = 1;
  localparam int          IRQ_START      = 2;
  localparam int          IRQ_STOP       = 3;
  // bit counts and AXI response codes
  localparam logic [3:0]  TX_LAST_BIT    = 4'h8;
  localparam logic [3:0]  RX_LAST_BIT    = 4'h7;
  localparam logic [1:0]  RESP_OKAY      = 2'h0;
  localparam logic [1:0]  RESP_SLVERR    = 2'h2;

  typedef enum logic [3:0] {
    ST_IDLE, ST_WAIT, ST_START1, ST_START2, ST_RS0, ST_RS1, ST_RS2,
    ST_STOP0, ST_STOP1, ST_STOP2, ST_BIT_LOW, ST_BIT_HIGH
  } i2cm_state_e;

  typedef enum logic [1:0] {OP_TX, OP_RX, OP_ACK} i2cm_op_e;
endpackage

//--- core/i2cm_sync.sv
// two flip-flop synchroniser for the bus pins
`timescale 1ns/1ps
module i2cm_sync #(
  parameter int W = 2
) (
  input  wire logic         clk,
  input  wire logic         reset,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);
  logic [W-1:0] meta_reg;

  for (genvar i = 0; i < W; i++) begin : g_bit
    always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
        meta_reg[i] <= 1'b1;
        dout[i]     <= 1'b1;
      end else begin
        meta_reg[i] <= din[i];
        dout[i]     <= meta_reg[i];
      end
    end
  end
endmodule

//--- core/i2cm_master.sv
// two-wire bus master with clock and bus arbitration, AXI4-Lite registers
// Behaviour
// [RULE1] software reload = fcy/fscl - fcy/1111111 - 1
// [RULE2] counter frozen until released scl reads high
// [RULE3] scl seen high reloads counter and counts
// [RULE4] released sda read low flags collision
// [RULE5] collision pulses master event, master goes idle
// [RULE6] collision stops send, clears buffer full, frees lines
// [RULE7] collision aborts sequences, clears request bits; here a control word write in that cycle wins and is kept
// [RULE8] after collision, bus stop sets master event
// [RULE9] transmit write always starts at first bit
// [RULE10] bus start and stop raise interrupts
// [RULE11] software starts only when bus free
// [RULE12] sda stable while scl high
// [RULE13] sleep aborts transfers and releases lines
// [RULE14] idle halts module when halt bit set
// [RULE15] counter counts to zero then stops
// [RULE16] software never loads reload with 0 or 1
// [RULE17] bus pins synchronised before any use
//
// The AXI4-Lite slave port was decided locally.
`timescale 1ns/1ps
module i2cm_master (
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic        sleep_req,
  input  wire logic        cpu_idle,
  input  wire logic        scl_in,
  output logic             scl_out,
  output logic             scl_oe,
  input  wire logic        sda_in,
  output logic             sda_out,
  output logic             sda_oe,
  output logic             irq,
  input  wire logic [15:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [15:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);
  i2cm_pkg::i2cm_state_e state_reg;
  i2cm_pkg::i2cm_op_e    op_reg;
  logic [1:0]  pins_s;
  logic        scl_s, sda_s, scl_d_reg, sda_d_reg;
  logic        bus_start, bus_stop, halted, run, high_state, load, done;
  logic        coll, check_bit, drive_bit, last_bit, byte_end;
  logic        fin_start, fin_rs, fin_stop, timing_reg, lost_reg;
  logic [15:0] cnt_reg, reload_reg, ctrl_reg, trn_reg, rcv_reg;
  logic [15:0] trn_wdata, status_word, rd_val;
  logic [3:0]  bit_cnt_reg;
  logic [7:0]  shift_reg;
  logic        ack_status_reg, tx_full_reg, rx_full_reg;
  logic        s_seen_reg, p_seen_reg;
  logic [3:0]  irq_stat_reg, irq_en_reg, ev;
  logic        aw_hold_reg, w_hold_reg, wr_fire, trn_wr, rd_fire, rd_ok;
  logic [15:0] aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0]  w_strb_reg;
  logic [13:0] wr_idx, rd_idx;

  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [31:0] d,
                                          input logic [3:0]  s);
    merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
  endfunction

  assign scl_out = 1'b0;
  assign sda_out = 1'b0;

  // pin synchroniser and bus condition detect
  i2cm_sync #(.W(2)) u_sync (
    .clk   (clk),
    .reset (reset),
    .din   ({scl_in, sda_in}),
    .dout  (pins_s)
  ); // RULE17
  assign scl_s = pins_s[1];
  assign sda_s = pins_s[0];

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      scl_d_reg <= 1'b1;
      sda_d_reg <= 1'b1;
    end else begin
      scl_d_reg <= scl_s;
      sda_d_reg <= sda_s;
    end
  end

  assign bus_start = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
  assign bus_stop  = scl_s & scl_d_reg & ~sda_d_reg & sda_s;

  // sequencing terms
  assign halted = cpu_idle & ctrl_reg[i2cm_pkg::CTL_HALT_IDLE]; // RULE14
  assign run    = ctrl_reg[i2cm_pkg::CTL_EN] & ~halted & ~sleep_req;
  assign high_state = (state_reg == i2cm_pkg::ST_START1) ||
                      (state_reg == i2cm_pkg::ST_RS1) ||
                      (state_reg == i2cm_pkg::ST_STOP1) ||
                      (state_reg == i2cm_pkg::ST_BIT_HIGH);
  assign load = run && !timing_reg && (!high_state || scl_s) &&
                state_reg != i2cm_pkg::ST_IDLE &&
                state_reg != i2cm_pkg::ST_WAIT; // RULE2 RULE3
  assign done = timing_reg && cnt_reg == 16'h0000;
  assign last_bit = (op_reg == i2cm_pkg::OP_TX) ?
                    bit_cnt_reg == i2cm_pkg::TX_LAST_BIT :
                    (op_reg == i2cm_pkg::OP_RX) ?
                    bit_cnt_reg == i2cm_pkg::RX_LAST_BIT : 1'b1;
  assign drive_bit = (op_reg == i2cm_pkg::OP_TX) ?
                     (bit_cnt_reg == i2cm_pkg::TX_LAST_BIT || shift_reg[7]) :
                     (op_reg == i2cm_pkg::OP_RX) ? 1'b1 :
                     ctrl_reg[i2cm_pkg::CTL_ACK_VAL];
  assign check_bit = (op_reg == i2cm_pkg::OP_ACK) ||
                     (op_reg == i2cm_pkg::OP_TX &&
                      bit_cnt_reg != i2cm_pkg::TX_LAST_BIT);
  // a released sda that reads low means another master won
  assign coll = run && done && !sda_s &&
                ((state_reg == i2cm_pkg::ST_START1) ||
                 (state_reg == i2cm_pkg::ST_RS1) ||
                 (state_reg == i2cm_pkg::ST_STOP2) ||
                 (state_reg == i2cm_pkg::ST_BIT_HIGH &&
                  check_bit && drive_bit)); // RULE4
  assign fin_start = run && done && state_reg == i2cm_pkg::ST_START2;
  assign fin_rs    = run && done && state_reg == i2cm_pkg::ST_RS2;
  assign fin_stop  = !coll && run && done && state_reg == i2cm_pkg::ST_STOP2;
  assign byte_end  = !coll && run && done && last_bit &&
                     state_reg == i2cm_pkg::ST_BIT_HIGH;

  // bit-rate counter
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cnt_reg <= 16'h0000;
    end else if (run) begin
      if (load) begin
        cnt_reg <= reload_reg; // RULE3
      end else if (cnt_reg != 16'h0000) begin
        cnt_reg <= cnt_reg - 16'h0001; // RULE15
      end
    end
  end

  // master sequencer
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state_reg      <= i2cm_pkg::ST_IDLE;
      op_reg         <= i2cm_pkg::OP_TX;
      bit_cnt_reg    <= 4'h0;
      shift_reg      <= 8'h00;
      timing_reg     <= 1'b0;
      scl_oe         <= 1'b0;
      sda_oe         <= 1'b0;
      ack_status_reg <= 1'b0;
      rcv_reg        <= i2cm_pkg::RST_RCV;
    end else if (sleep_req || !ctrl_reg[i2cm_pkg::CTL_EN] || coll) begin
      state_reg  <= i2cm_pkg::ST_IDLE; // RULE5 RULE13
      timing_reg <= 1'b0;
      scl_oe     <= 1'b0; // RULE6 RULE7
      sda_oe     <= 1'b0;
    end else if (!halted) begin
      if (load) begin
        timing_reg <= 1'b1;
      end
      unique case (state_reg)
        i2cm_pkg::ST_IDLE: begin
          if (ctrl_reg[i2cm_pkg::CTL_START_REQ]) begin
            state_reg  <= i2cm_pkg::ST_START1;
            timing_reg <= 1'b0;
          end
        end
        i2cm_pkg::ST_WAIT: begin
          timing_reg <= 1'b0;
          if (trn_wr) begin
            state_reg   <= i2cm_pkg::ST_BIT_LOW;
            op_reg      <= i2cm_pkg::OP_TX;
            bit_cnt_reg <= 4'h0; // RULE9
            shift_reg   <= trn_wdata[7:0];
          end else if (ctrl_reg[i2cm_pkg::CTL_RS_REQ]) begin
            state_reg <= i2cm_pkg::ST_RS0;
            sda_oe    <= 1'b0;
          end else if (ctrl_reg[i2cm_pkg::CTL_STOP_REQ]) begin
            state_reg <= i2cm_pkg::ST_STOP0;
            sda_oe    <= 1'b1;
          end else if (ctrl_reg[i2cm_pkg::CTL_RX_REQ]) begin
            state_reg   <= i2cm_pkg::ST_BIT_LOW;
            op_reg      <= i2cm_pkg::OP_RX;
            bit_cnt_reg <= 4'h0;
          end else if (ctrl_reg[i2cm_pkg::CTL_ACK_REQ]) begin
            state_reg   <= i2cm_pkg::ST_BIT_LOW;
            op_reg      <= i2cm_pkg::OP_ACK;
            bit_cnt_reg <= 4'h0;
          end
        end
        i2cm_pkg::ST_START1, i2cm_pkg::ST_RS1: begin
          if (done) begin
            sda_oe     <= 1'b1;
            state_reg  <= (state_reg == i2cm_pkg::ST_RS1) ?
                          i2cm_pkg::ST_RS2 : i2cm_pkg::ST_START2;
            timing_reg <= 1'b0;
          end
        end
        i2cm_pkg::ST_START2, i2cm_pkg::ST_RS2: begin
          if (done) begin
            scl_oe    <= 1'b1;
            state_reg <= i2cm_pkg::ST_WAIT;
          end
        end
        i2cm_pkg::ST_RS0, i2cm_pkg::ST_STOP0: begin
          if (done) begin
            scl_oe     <= 1'b0; // RULE2
            state_reg  <= (state_reg == i2cm_pkg::ST_RS0) ?
                          i2cm_pkg::ST_RS1 : i2cm_pkg::ST_STOP1;
            timing_reg <= 1'b0;
          end
        end
        i2cm_pkg::ST_STOP1: begin
          if (done) begin
            sda_oe     <= 1'b0;
            state_reg  <= i2cm_pkg::ST_STOP2;
            timing_reg <= 1'b0;
          end
        end
        i2cm_pkg::ST_STOP2: begin
          if (done) begin
            state_reg <= i2cm_pkg::ST_IDLE;
          end
        end
        i2cm_pkg::ST_BIT_LOW: begin
          sda_oe <= ~drive_bit; // RULE12
          if (done) begin
            scl_oe     <= 1'b0; // RULE2
            state_reg  <= i2cm_pkg::ST_BIT_HIGH;
            timing_reg <= 1'b0;
          end
        end
        i2cm_pkg::ST_BIT_HIGH: begin
          if (done) begin
            scl_oe     <= 1'b1;
            timing_reg <= 1'b0;
            shift_reg  <= {shift_reg[6:0], sda_s};
            if (last_bit) begin
              state_reg <= i2cm_pkg::ST_WAIT;
              if (op_reg == i2cm_pkg::OP_TX) begin
                ack_status_reg <= sda_s;
              end
              if (op_reg == i2cm_pkg::OP_RX) begin
                rcv_reg <= {8'h00, shift_reg[6:0], sda_s};
              end
            end else begin
              bit_cnt_reg <= bit_cnt_reg + 4'h1;
              state_reg   <= i2cm_pkg::ST_BIT_LOW;
            end
          end
        end
      endcase
    end
  end

  // control word: software sets, hardware clears on end or collision
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ctrl_reg   <= i2cm_pkg::RST_CTRL;
      reload_reg <= i2cm_pkg::RST_RELOAD;
      trn_reg    <= i2cm_pkg::RST_TRN;
      irq_en_reg <= i2cm_pkg::RST_IRQ;
    end else begin
      if (wr_fire && wr_idx == i2cm_pkg::IDX_CTRL) begin
        ctrl_reg <= merge16(ctrl_reg, w_data_reg, w_strb_reg);
      end else if (coll) begin
        ctrl_reg <= ctrl_reg & ~i2cm_pkg::CTL_REQ_MASK; // RULE7
      end else begin
        if (fin_start) ctrl_reg[i2cm_pkg::CTL_START_REQ] <= 1'b0;
        if (fin_rs)    ctrl_reg[i2cm_pkg::CTL_RS_REQ]    <= 1'b0;
        if (fin_stop)  ctrl_reg[i2cm_pkg::CTL_STOP_REQ]  <= 1'b0;
        if (byte_end && op_reg == i2cm_pkg::OP_RX)
          ctrl_reg[i2cm_pkg::CTL_RX_REQ] <= 1'b0;
        if (byte_end && op_reg == i2cm_pkg::OP_ACK)
          ctrl_reg[i2cm_pkg::CTL_ACK_REQ] <= 1'b0;
      end
      if (wr_fire && wr_idx == i2cm_pkg::IDX_RELOAD)
        reload_reg <= merge16(reload_reg, w_data_reg, w_strb_reg);
      if (trn_wr)
        trn_reg <= trn_wdata;
      if (wr_fire && wr_idx == i2cm_pkg::IDX_IRQ_EN)
        irq_en_reg <= w_data_reg[3:0] & {4{w_strb_reg[0]}} |
                      irq_en_reg & {4{~w_strb_reg[0]}};
    end
  end

  // status flags and interrupts
  assign ev[i2cm_pkg::IRQ_MASTER] = coll | fin_start | fin_rs | fin_stop |
                                    byte_end | (lost_reg & bus_stop); // RULE5 RULE8
  assign ev[i2cm_pkg::IRQ_COLL]   = coll;
  assign ev[i2cm_pkg::IRQ_START]  = bus_start; // RULE10
  assign ev[i2cm_pkg::IRQ_STOP]   = bus_stop;  // RULE10

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      tx_full_reg  <= 1'b0;
      rx_full_reg  <= 1'b0;
      lost_reg     <= 1'b0;
      s_seen_reg   <= 1'b0;
      p_seen_reg   <= 1'b0;
      irq_stat_reg <= i2cm_pkg::RST_IRQ;
      irq          <= 1'b0;
    end else begin
      if (trn_wr && state_reg == i2cm_pkg::ST_WAIT && !coll) begin
        tx_full_reg <= 1'b1;
      end else if (coll || byte_end || sleep_req) begin
        tx_full_reg <= 1'b0; // RULE6
      end
      if (byte_end && op_reg == i2cm_pkg::OP_RX) rx_full_reg <= 1'b1;
      else if (rd_fire && rd_idx == i2cm_pkg::IDX_RCV) rx_full_reg <= 1'b0;
      if (coll) lost_reg <= 1'b1;
      else if (bus_stop) lost_reg <= 1'b0; // RULE8
      if (bus_start) begin
        s_seen_reg <= 1'b1;
        p_seen_reg <= 1'b0;
      end else if (bus_stop) begin
        s_seen_reg <= 1'b0;
        p_seen_reg <= 1'b1;
      end
      irq_stat_reg <= (irq_stat_reg & ~((wr_fire && w_strb_reg[0] &&
                      wr_idx == i2cm_pkg::IDX_IRQ_CLR) ?
                      w_data_reg[3:0] : 4'h0)) | ev;
      irq <= |(irq_stat_reg & irq_en_reg);
    end
  end

  always_comb begin
    status_word = 16'h0000;
    status_word[i2cm_pkg::ST_ACK]       = ack_status_reg;
    status_word[i2cm_pkg::ST_TX_ACTIVE] = op_reg == i2cm_pkg::OP_TX &&
      (state_reg == i2cm_pkg::ST_BIT_LOW || state_reg == i2cm_pkg::ST_BIT_HIGH);
    status_word[i2cm_pkg::ST_COLL]      = lost_reg;
    status_word[i2cm_pkg::ST_STOP]      = p_seen_reg;
    status_word[i2cm_pkg::ST_START]     = s_seen_reg;
    status_word[i2cm_pkg::ST_RX_FULL]   = rx_full_reg;
    status_word[i2cm_pkg::ST_TX_FULL]   = tx_full_reg;
  end

  // AXI4-Lite slave
  assign wr_idx    = aw_addr_reg[15:2];
  assign rd_idx    = s_axi_araddr[15:2];
  assign wr_fire   = aw_hold_reg && w_hold_reg && !s_axi_bvalid;
  assign trn_wr    = wr_fire && wr_idx == i2cm_pkg::IDX_TRN;
  assign trn_wdata = merge16(trn_reg, w_data_reg, w_strb_reg);
  assign rd_fire   = s_axi_arvalid && s_axi_arready;

  always_comb begin
    rd_ok  = 1'b1;
    rd_val = 16'h0000;
    unique case (rd_idx)
      i2cm_pkg::IDX_RCV:      rd_val = rcv_reg;
      i2cm_pkg::IDX_TRN:      rd_val = trn_reg;
      i2cm_pkg::IDX_RELOAD:   rd_val = reload_reg;
      i2cm_pkg::IDX_CTRL:     rd_val = ctrl_reg;
      i2cm_pkg::IDX_STAT:     rd_val = status_word;
      i2cm_pkg::IDX_IRQ_STAT: rd_val = {12'h000, irq_stat_reg};
      i2cm_pkg::IDX_IRQ_CLR:  rd_val = 16'h0000;
      i2cm_pkg::IDX_IRQ_EN:   rd_val = {12'h000, irq_en_reg};
      default:                rd_ok  = 1'b0;
    endcase
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      aw_hold_reg   <= 1'b0;
      w_hold_reg    <= 1'b0;
      aw_addr_reg   <= 16'h0000;
      w_data_reg    <= 32'h00000000;
      w_strb_reg    <= 4'h0;
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= i2cm_pkg::RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_reg   <= 1'b1;
        aw_addr_reg   <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_reg   <= 1'b1;
        w_data_reg   <= s_axi_wdata;
        w_strb_reg   <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (wr_fire) begin
        aw_hold_reg  <= 1'b0;
        w_hold_reg   <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (wr_idx >= i2cm_pkg::IDX_RCV &&
                         wr_idx <= i2cm_pkg::IDX_IRQ_EN && !wr_idx[0]) ?
                        i2cm_pkg::RESP_OKAY : i2cm_pkg::RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= i2cm_pkg::RESP_OKAY;
    end else if (rd_fire) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= {16'h0000, rd_val};
      s_axi_rresp   <= rd_ok ? i2cm_pkg::RESP_OKAY : i2cm_pkg::RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // checks
  default clocking @(posedge clk); endclocking
  default disable iff (reset);

  chk_rate_frozen: assert property (high_state && run && !timing_reg && !scl_s
    && !coll |=> !timing_reg) // RULE2
    else $error("counter started before scl read high");
  chk_rate_reload: assert property (load |=> timing_reg &&
    cnt_reg == $past(reload_reg)) // RULE3
    else $error("counter not reloaded when scl read high");
  chk_rate_count: assert property (run && !load && cnt_reg != 16'h0000 |=>
    cnt_reg == $past(cnt_reg) - 16'h0001) // RULE15
    else $error("counter did not count down");
  chk_rate_stop: assert property (cnt_reg == 16'h0000 && !load |=>
    cnt_reg == 16'h0000) // RULE15
    else $error("counter moved past zero");
  chk_coll_idle: assert property (coll |=> state_reg == i2cm_pkg::ST_IDLE &&
    irq_stat_reg[i2cm_pkg::IRQ_MASTER] && lost_reg) // RULE4 RULE5
    else $error("collision did not idle the master");
  chk_coll_release: assert property (coll |=> !tx_full_reg && !scl_oe &&
    !sda_oe ##1 !scl_oe) // RULE6
    else $error("collision left lines driven");
  chk_coll_reqs: assert property (coll && !(wr_fire &&
    wr_idx == i2cm_pkg::IDX_CTRL) |=>
    (ctrl_reg & i2cm_pkg::CTL_REQ_MASK) == 16'h0000) // RULE7
    else $error("collision kept request bits");
  chk_lost_stop: assert property (lost_reg && bus_stop |=>
    irq_stat_reg[i2cm_pkg::IRQ_MASTER] && !lost_reg) // RULE8
    else $error("stop after collision not flagged");
  chk_tx_first: assert property (trn_wr && state_reg == i2cm_pkg::ST_WAIT &&
    run && !coll |=> bit_cnt_reg == 4'h0 && op_reg == i2cm_pkg::OP_TX) // RULE9
    else $error("transmit did not start at first bit");
  chk_bus_events: assert property (bus_start |=> s_seen_reg && !p_seen_reg &&
    irq_stat_reg[i2cm_pkg::IRQ_START]) // RULE10
    else $error("bus start not flagged");
  chk_sda_stable: assert property (state_reg == i2cm_pkg::ST_BIT_HIGH &&
    $past(state_reg) == i2cm_pkg::ST_BIT_HIGH |-> $stable(sda_oe)) // RULE12
    else $error("sda changed while scl high");
  chk_sleep_abort: assert property (sleep_req |=>
    state_reg == i2cm_pkg::ST_IDLE && !scl_oe && !sda_oe) // RULE13
    else $error("sleep did not abort");
  chk_idle_halt: assert property (halted && !sleep_req && !coll &&
    ctrl_reg[i2cm_pkg::CTL_EN] |=> $stable(state_reg) &&
    $stable(cnt_reg)) // RULE14
    else $error("module ran while halted in idle");

  cov_tx_byte: cover property (byte_end && op_reg == i2cm_pkg::OP_TX);
  cov_collision: cover property (coll ##[1:1000] bus_stop);
  cov_stretch: cover property (state_reg == i2cm_pkg::ST_BIT_HIGH &&
    !scl_s [*4] ##1 load);
endmodule

//--- tb/i2cm_peer.sv
// open-drain bus with another party that stretches scl or pulls sda
`timescale 1ns/1ps
module i2cm_peer (
  input  wire logic scl_oe,
  input  wire logic sda_oe,
  input  wire logic stretch,
  input  wire logic pull,
  output logic      scl,
  output logic      sda
);
  assign scl = !(scl_oe || stretch);
  assign sda = !(sda_oe || pull);
endmodule

//--- tb/i2c_master_arbitration_bench.sv
// register and arbitration tests for the two-wire master
`timescale 1ns/1ps
module i2c_master_arbitration_bench;
  logic        clk = 1'b0, reset = 1'b1, sleep_req = 1'b0, cpu_idle = 1'b0;
  logic        str = 1'b0, pul = 1'b0, irq, scl_in, sda_in;
  logic        scl_out, scl_oe, sda_out, sda_oe;
  logic [15:0] s_axi_awaddr = 16'h0, s_axi_araddr = 16'h0, v;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic        s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
  int          n_mismatch = 0, comparisons = 0, k;
  always #5 clk = ~clk;
  i2cm_peer i_peer (.scl_oe(scl_oe), .sda_oe(sda_oe), .stretch(str),
                    .pull(pul), .scl(scl_in), .sda(sda_in));
  i2cm_master i_dut (.*);
  task chk(input logic [15:0] s, input logic [15:0] e);
    comparisons++;
    if (s !== e) begin
      n_mismatch++;
      $display("[ERR] %0t seen %h expected %h", $time, s, e);
    end
  endtask
  task wr(input logic [13:0] i, input logic [15:0] d);
    logic a, w, b, sa, sw, sb;
    @(posedge clk);
    s_axi_awaddr <= {i, 2'b00};
    s_axi_wdata <= {16'h0000, d};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
    {a, w, b} = 3'b111;
    while (b) begin
      @(negedge clk);
      {sa, sw, sb} = {s_axi_awready, s_axi_wready, s_axi_bvalid};
      resp = s_axi_bresp;
      @(posedge clk);
      {a, w, b} = {a & !sa, w & !sw, b & !sb};
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {a, w, b};
    end
  endtask
  task rd(input logic [13:0] i, output logic [15:0] d);
    logic a, b, sa, sb;
    @(posedge clk);
    s_axi_araddr <= {i, 2'b00};
    {s_axi_arvalid, s_axi_rready} <= 2'b11;
    {a, b} = 2'b11;
    while (b) begin
      @(negedge clk);
      {sa, sb} = {s_axi_arready, s_axi_rvalid};
      d = s_axi_rdata[15:0];
      resp = s_axi_rresp;
      @(posedge clk);
      {a, b} = {a & !sa, b & !sb};
      {s_axi_arvalid, s_axi_rready} <= {a, b};
    end
  endtask
  task wait_oe(input logic e);
    k = 0;
    do begin
      @(negedge clk);
      k++;
    end while (scl_oe !== e && k < 3000);
    chk({15'h0, scl_oe}, {15'h0, e});
    if (e) chk({15'h0, irq}, 16'h0000);
    @(posedge clk);
  endtask
  task wirq;
    k = 0;
    do begin
      @(negedge clk);
      k++;
    end while (irq !== 1'b1 && k < 3000);
    chk({15'h0, irq}, 16'h0001);
    @(posedge clk);
  endtask
  task wrap_up;
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    rd(i2cm_pkg::IDX_RCV, v);
    chk(v, 16'h0000);
    rd(i2cm_pkg::IDX_TRN, v);
    chk(v, 16'h00FF);
    rd(14'h0201, v);
    chk({14'h0, resp}, 16'h0002);
    wr(14'h0201, 16'h0000);
    chk({14'h0, resp}, 16'h0002);
    wr(i2cm_pkg::IDX_RELOAD, 16'h0007);
    chk({14'h0, resp}, 16'h0000);
    wr(i2cm_pkg::IDX_IRQ_EN, 16'h0001);
    rd(i2cm_pkg::IDX_STAT, v);
    chk(v & 16'h0018, 16'h0000);
    wr(i2cm_pkg::IDX_CTRL, 16'h8001);
    wirq;
    rd(i2cm_pkg::IDX_IRQ_STAT, v);
    chk(v, 16'h0005);
    wr(i2cm_pkg::IDX_IRQ_CLR, 16'h000F);
    str <= 1'b1;
    wr(i2cm_pkg::IDX_TRN, 16'h00A5);
    wait_oe(1'b0);
    repeat (30) begin
      @(negedge clk);
      chk({15'h0, scl_oe}, 16'h0000);
    end
    @(posedge clk);
    str <= 1'b0;
    wait_oe(1'b1);
    chk({15'h0, k >= 8}, 16'h0001);
    wirq;
    wr(i2cm_pkg::IDX_IRQ_CLR, 16'h000F);
    wr(i2cm_pkg::IDX_TRN, 16'h00FF);
    pul <= 1'b1;
    wirq;
    rd(i2cm_pkg::IDX_IRQ_STAT, v);
    chk(v, 16'h0003);
    rd(i2cm_pkg::IDX_STAT, v);
    chk(v & 16'h0401, 16'h0400);
    rd(i2cm_pkg::IDX_CTRL, v);
    chk(v & 16'h001F, 16'h0000);
    chk({12'h0, scl_out, sda_out, scl_oe, sda_oe}, 16'h0000);
    wr(i2cm_pkg::IDX_IRQ_CLR, 16'h000F);
    pul <= 1'b0;
    wirq;
    rd(i2cm_pkg::IDX_IRQ_STAT, v);
    chk(v, 16'h0009);
    rd(i2cm_pkg::IDX_STAT, v);
    chk(v & 16'h0418, 16'h0010);
    wr(i2cm_pkg::IDX_IRQ_CLR, 16'h000F);
    cpu_idle <= 1'b1;
    wr(i2cm_pkg::IDX_CTRL, 16'hA001);
    repeat (40) @(posedge clk);
    rd(i2cm_pkg::IDX_IRQ_STAT, v);
    chk(v, 16'h0000);
    cpu_idle <= 1'b0;
    wirq;
    rd(i2cm_pkg::IDX_IRQ_STAT, v);
    chk(v, 16'h0005);
    chk({14'h0, scl_oe, sda_oe}, 16'h0003);
    sleep_req <= 1'b1;
    repeat (3) @(negedge clk);
    chk({14'h0, scl_oe, sda_oe}, 16'h0000);
    wrap_up;
  end
  initial begin
    #300000;
    n_mismatch++;
    wrap_up;
  end
endmodule
